// ===== hw/line_status_change_monitor.sv
// file: status change monitor for one line, receive and transmit channels
// Functional notes
// - scan-enable bit 0 of change control starts scanning; zero stops it
// - any masked difference copies the whole adapter status into the copy
// - control bit 1 on a recorded change sets status byte 2 bit 3
// - control bit 2 terminates the control block, interrupts host, sets status1 bit 1
// - control bit 3 starts channel program, only when bit 2 is clear
// - host and channel program may both rewrite change control at any time
// - return channel number and level go out with every host interrupt
// - with scan disabled the stored copy is neither used nor updated
// - copy bits: dsr, cts, carrier, ring, ready, reserved, overrun, framing
// - ready bit 4 encodes fifo state for buffered adapters
// - ready branch reads adapter status and branches on bit 4
// - status bit 6 marks receive overrun
// - status bit 7 marks framing error on asynchronous adapters
// - transmit send picks up bit 7 and sets status1 bit 2
// - synchronous late service sends fill character and sets bit 7
// - each mask bit enables change detection for its own position
// - host and channel program may both rewrite the mask
`timescale 1ns/100ps
module line_status_change_monitor (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  // host register access
  input  wire line_status_pkg::reg_req_s    host_req,
  output logic [7:0]                        host_rdata,
  // channel program register access
  input  wire line_status_pkg::reg_req_s    cp_req,
  output logic [7:0]                        cp_rdata,
  // adapter status registers (line register 5)
  input  wire logic [7:0]                   adapter_status_rx,
  input  wire logic [7:0]                   adapter_status_tx,
  // control block and send events
  input  wire logic                         ccb_begin,
  input  wire logic                         ccb_chan,
  input  wire logic                         send_req,
  // adapter-ready branch
  input  wire logic                         br_req,
  input  wire logic                         br_chan,
  input  wire logic                         br_on_set,
  output logic                              br_done,
  output logic                              br_taken,
  // actions toward firmware and system bus
  output logic                              term_pulse,
  output logic                              start_pulse,
  output logic                              action_chan,
  output line_status_pkg::intr_s            intr,
  input  wire logic                         intr_ack
);
  import line_status_pkg::*;

  // all block state but the return info store lives in one register; the comb process builds its successor
  typedef struct packed {
    scan_state_e     st;
    logic            scan_ch;
    logic            ich;
    chan_regs_s [1:0] chn;
    logic [7:0]      host_rdata;
    logic            host_mem_sel;
    logic            host_mem_low;
    logic [7:0]      cp_rdata;
    logic            term_pulse;
    logic            start_pulse;
    logic            action_chan;
    logic            br_done;
    logic            br_taken;
  } state_s;

  state_s r;
  state_s next_r;

  logic [15:0] mem_a_q;
  logic [15:0] mem_b_q;
  logic        mem_we;
  logic [7:0]  ad [2];
  logic [7:0]  diff;
  logic        change;

  // both line registers are read live; the scan alternates between them
  assign ad[CH_RX] = adapter_status_rx;
  assign ad[CH_TX] = adapter_status_tx;

  // ==========================================================================
  // helpers
  function automatic logic is_ret_byte(input logic [4:0] a);
    return (a == OFS_RET_HI) || (a == OFS_RET_LVL);
  endfunction

  function automatic logic [7:0] read_byte(input chan_regs_s c, input logic [4:0] a);
    case (a)
      OFS_CTL:   read_byte = {4'h0, c.ctl};
      OFS_COPY:  read_byte = c.copy;
      OFS_MASK:  read_byte = c.mask;
      OFS_STAT1: read_byte = c.stat1;
      OFS_STAT2: read_byte = c.stat2;
      default:   read_byte = BYTE_RESET;
    endcase
  endfunction

  // copy is never writable here; only stat1 programming bits are open to the cp
  function automatic chan_regs_s write_byte(input chan_regs_s c, input logic [4:0] a,
                                            input logic [7:0] d, input logic from_cp);
    chan_regs_s o;
    o = c;
    case (a)
      OFS_CTL:   o.ctl = d[CTL_W-1:0];
      OFS_MASK:  o.mask = d;
      OFS_STAT1: begin
        if (from_cp) begin
          o.stat1 = (c.stat1 & ~STAT1_PROG_MASK) | (d & STAT1_PROG_MASK);
        end
      end
      default:   o = c;
    endcase
    return o;
  endfunction

  // ==========================================================================
  // return channel / level store
  // only the host port reaches this store, so channel program writes fall away
  assign mem_we = host_req.wr && is_ret_byte(host_req.addr[4:0]);

  return_info_mem u_ret (
    .core_clk (core_clk),
    .reset    (reset),
    .we       (mem_we),
    .wchan    (host_req.addr[CHAN_BIT]),
    .wlow     (host_req.addr[4:0] == OFS_RET_LVL),
    .wdata    (host_req.wdata),
    .ra_chan  (host_req.addr[CHAN_BIT]),
    .ra_q     (mem_a_q),
    .rb_chan  (r.ich),
    .rb_q     (mem_b_q)
  );

  // ==========================================================================
  // scan comparison of the channel under scan
  // each channel is looked at every second cycle; a change is seen within two
  assign diff   = (ad[r.scan_ch] ^ r.chn[r.scan_ch].copy) & r.chn[r.scan_ch].mask;
  assign change = (r.st == ST_SCAN) && r.chn[r.scan_ch].ctl[CTL_SCAN] && (|diff);

  always_comb begin
    next_r             = r;
    next_r.term_pulse  = 1'b0;
    next_r.start_pulse = 1'b0;
    next_r.br_done     = 1'b0;
    next_r.host_mem_sel = 1'b0;

    // register reads
    if (host_req.rd) begin
      next_r.host_rdata   = read_byte(r.chn[host_req.addr[CHAN_BIT]], host_req.addr[4:0]);
      next_r.host_mem_sel = is_ret_byte(host_req.addr[4:0]);
      next_r.host_mem_low = host_req.addr[4:0] == OFS_RET_LVL;
    end
    if (cp_req.rd) begin
      next_r.cp_rdata = read_byte(r.chn[cp_req.addr[CHAN_BIT]], cp_req.addr[4:0]);
    end

    // writes: channel program first, host last; hardware sets below win over both
    if (cp_req.wr) begin
      next_r.chn[cp_req.addr[CHAN_BIT]] =
        write_byte(next_r.chn[cp_req.addr[CHAN_BIT]], cp_req.addr[4:0], cp_req.wdata, 1'b1);
    end
    if (host_req.wr) begin
      next_r.chn[host_req.addr[CHAN_BIT]] =
        write_byte(next_r.chn[host_req.addr[CHAN_BIT]], host_req.addr[4:0],
                   host_req.wdata, 1'b0);
    end

    // a new control block starts with clean status bytes
    if (ccb_begin) begin
      next_r.chn[ccb_chan].stat1 = BYTE_RESET;
      next_r.chn[ccb_chan].stat2 = BYTE_RESET;
    end

    // transmit send picks up the underrun / framing bit
    // limitation: the flag is only set here; clearing it needs a new control block
    if (send_req && ad[CH_TX][LS_FRAMING]) begin
      next_r.chn[CH_TX].stat1[STAT1_SERVICE_ERR] = 1'b1;
    end

    // adapter-ready branch reads the live adapter register
    if (br_req) begin
      next_r.br_done  = 1'b1;
      next_r.br_taken = (ad[br_chan][LS_READY] == br_on_set);
    end

    case (r.st)
      // the copy is reloaded at once, so one change gives one set of actions
      ST_SCAN: begin
        next_r.scan_ch = ~r.scan_ch;
        if (change) begin
          next_r.chn[r.scan_ch].copy = ad[r.scan_ch];
          next_r.action_chan = r.scan_ch;
          if (r.chn[r.scan_ch].ctl[CTL_FLAG]) begin
            next_r.chn[r.scan_ch].stat2[STAT2_CHANGE] = 1'b1;
          end
          if (r.chn[r.scan_ch].ctl[CTL_INTR]) begin
            next_r.term_pulse = 1'b1;
            next_r.chn[r.scan_ch].stat1[STAT1_CHANGE_INTR] = 1'b1;
            next_r.ich = r.scan_ch;
            next_r.st  = ST_FETCH;
          end else if (r.chn[r.scan_ch].ctl[CTL_START]) begin
            next_r.start_pulse = 1'b1;
          end
        end
      end
      // one cycle for the return info store to present this channel's bytes;
      // scan stays paused until the host takes the interrupt, later changes wait
      ST_FETCH: begin
        next_r.st = ST_SEND;
      end
      ST_SEND: begin
        if (intr_ack) begin
          next_r.st = ST_SCAN;
        end
      end
      default: begin
        next_r.st = ST_SCAN;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r <= '{st: ST_SCAN, chn: '{default: '{ctl: CTL_RESET, default: BYTE_RESET}},
             host_rdata: BYTE_RESET, cp_rdata: BYTE_RESET, default: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs
  // return bytes come from the store register, one cycle after the strobe like the rest
  assign host_rdata    = r.host_mem_sel ? (r.host_mem_low ? mem_a_q[7:0] : mem_a_q[15:8])
                                        : r.host_rdata;
  assign cp_rdata      = r.cp_rdata;
  assign br_done       = r.br_done;
  assign br_taken      = r.br_taken;
  assign term_pulse    = r.term_pulse;
  assign start_pulse   = r.start_pulse;
  assign action_chan   = r.action_chan;
  // channel number spans byte 12 and top two bits of byte 13
  assign intr.valid    = (r.st == ST_SEND);
  assign intr.chan_num = mem_b_q[15:6];
  assign intr.level    = mem_b_q[LEVEL_W-1:0];

  // ==========================================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  scan_off_hold_a: assert property (
    (r.st == ST_SCAN) && !r.chn[r.scan_ch].ctl[CTL_SCAN]
    |=> r.chn[$past(r.scan_ch)].copy == $past(r.chn[r.scan_ch].copy))
    else $error("copy changed while scan disabled");

  copy_update_a: assert property (
    change |=> r.chn[$past(r.scan_ch)].copy == $past(ad[r.scan_ch]))
    else $error("copy not loaded on masked change");

  mask_block_a: assert property (
    (r.st == ST_SCAN) && (diff == 8'h00)
    |=> r.chn[$past(r.scan_ch)].copy == $past(r.chn[r.scan_ch].copy))
    else $error("copy changed without masked difference");

  change_flag_a: assert property (
    change && r.chn[r.scan_ch].ctl[CTL_FLAG]
    |=> r.chn[$past(r.scan_ch)].stat2[STAT2_CHANGE])
    else $error("change flag not set");

  term_intr_a: assert property (
    change && r.chn[r.scan_ch].ctl[CTL_INTR]
    |=> term_pulse && !start_pulse ##2 intr.valid)
    else $error("terminate or interrupt missing");

  start_only_a: assert property (
    change && !r.chn[r.scan_ch].ctl[CTL_INTR] && r.chn[r.scan_ch].ctl[CTL_START]
    |=> start_pulse && !term_pulse && !intr.valid)
    else $error("channel program start missing");

  intr_hold_a: assert property (
    intr.valid && !intr_ack && !mem_we && !$past(mem_we)
    |=> intr.valid && $stable(intr.chan_num) && $stable(intr.level))
    else $error("interrupt payload dropped before ack");

  intr_source_a: assert property (
    $rose(intr.valid) |-> (r.ich == action_chan))
    else $error("interrupt raised for the wrong channel");

  single_term_a: assert property (
    term_pulse |=> !term_pulse && !start_pulse)
    else $error("second action from one recorded change");

  action_excl_a: assert property (
    term_pulse |-> !start_pulse)
    else $error("start issued together with terminate");

  ctl_write_a: assert property (
    cp_req.wr && !host_req.wr && (cp_req.addr[4:0] == OFS_CTL)
    |=> r.chn[$past(cp_req.addr[CHAN_BIT])].ctl == $past(cp_req.wdata[CTL_W-1:0]))
    else $error("change control write from channel program lost");

  mask_write_a: assert property (
    host_req.wr && (host_req.addr[4:0] == OFS_MASK)
    |=> r.chn[$past(host_req.addr[CHAN_BIT])].mask == $past(host_req.wdata))
    else $error("mask write from host lost");

  copy_readonly_a: assert property (
    cp_req.wr && (cp_req.addr[4:0] == OFS_COPY) && !change
    |=> r.chn[$past(cp_req.addr[CHAN_BIT])].copy == $past(r.chn[cp_req.addr[CHAN_BIT]].copy))
    else $error("stored copy written from channel program");

  stat2_ccb_a: assert property (
    ccb_begin && !change
    |=> r.chn[$past(ccb_chan)].stat2 == BYTE_RESET)
    else $error("status byte 2 not cleared for new control block");

  cp_no_ret_a: assert property (
    cp_req.wr && !host_req.wr |-> !mem_we)
    else $error("return info written from channel program");

  ctl_high_zero_a: assert property (
    host_req.rd && host_req.addr[4:0] == OFS_CTL |=> host_rdata[7:4] == 4'h0)
    else $error("control high nibble not zero");

  branch_a: assert property (
    br_req |=> br_done && (br_taken == ($past(ad[br_chan][LS_READY]) == $past(br_on_set))))
    else $error("ready branch wrong");

  send_pickup_a: assert property (
    send_req && ad[CH_TX][LS_FRAMING] |=> r.chn[CH_TX].stat1[STAT1_SERVICE_ERR])
    else $error("send did not pick up bit 7");

  // main scenarios
  cov_change_c:  cover property (change);
  cov_tx_intr_c: cover property (term_pulse && action_chan);
  cov_intr_c:    cover property (intr.valid ##1 intr_ack);
  cov_start_c:   cover property (start_pulse);
  cov_branch_c:  cover property (br_req && br_on_set ##1 br_taken);
endmodule // line_status_change_monitor

// ===== hw/line_status_pkg.sv
// package: constants, field layouts and carrier types of the line status change monitor
package line_status_pkg;

  // ==========================================================================
  // byte offsets within one channel's line control table (bit 5 selects tx)
  localparam logic [4:0] OFS_CTL     = 5'h08;
  localparam logic [4:0] OFS_RET_HI  = 5'h0c;
  localparam logic [4:0] OFS_RET_LVL = 5'h0d;
  localparam logic [4:0] OFS_COPY    = 5'h0e;
  localparam logic [4:0] OFS_MASK    = 5'h0f;
  localparam logic [4:0] OFS_STAT1   = 5'h10;
  localparam logic [4:0] OFS_STAT2   = 5'h11;
  localparam int         ADDR_W      = 6;
  localparam int         CHAN_BIT    = 5;

  // ==========================================================================
  // channel select
  localparam logic CH_RX = 1'b0;
  localparam logic CH_TX = 1'b1;

  // ==========================================================================
  // change-control byte fields
  localparam int         CTL_SCAN  = 0;
  localparam int         CTL_FLAG  = 1;
  localparam int         CTL_INTR  = 2;
  localparam int         CTL_START = 3;
  localparam int         CTL_W     = 4;

  // ==========================================================================
  // status byte fields
  localparam int         STAT1_CHANGE_INTR = 1;
  localparam int         STAT1_SERVICE_ERR = 2;
  localparam logic [7:0] STAT1_PROG_MASK   = 8'h60;
  localparam int         STAT2_CHANGE      = 3;

  // ==========================================================================
  // adapter status (line register 5) bit meanings
  localparam int LS_DSR     = 0;
  localparam int LS_CTS     = 1;
  localparam int LS_CARRIER = 2;
  localparam int LS_RING    = 3;
  localparam int LS_READY   = 4;
  localparam int LS_OVERRUN = 6;
  localparam int LS_FRAMING = 7;

  // ==========================================================================
  // reset values and return-info layout
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] CTL_RESET  = 4'h0;
  localparam int         LEVEL_W    = 6;
  localparam int         RETCH_W    = 10;

  typedef enum logic [2:0] {
    ST_SCAN  = 3'b001,
    ST_FETCH = 3'b010,
    ST_SEND  = 3'b100
  } scan_state_e;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } reg_req_s;

  typedef struct packed {
    logic               valid;
    logic [RETCH_W-1:0] chan_num;
    logic [LEVEL_W-1:0] level;
  } intr_s;

  typedef struct packed {
    logic [CTL_W-1:0] ctl;
    logic [7:0]       copy;
    logic [7:0]       mask;
    logic [7:0]       stat1;
    logic [7:0]       stat2;
  } chan_regs_s;

endpackage

// ===== hw/return_info_mem.sv
// file: two-entry store of return channel and interrupt level bytes
`timescale 1ns/100ps
module return_info_mem (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // write port
  input  wire logic        we,
  input  wire logic        wchan,
  input  wire logic        wlow,
  input  wire logic [7:0]  wdata,
  // read ports, data registered
  input  wire logic        ra_chan,
  output logic      [15:0] ra_q,
  input  wire logic        rb_chan,
  output logic      [15:0] rb_q
);
  logic [15:0] mem [2];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem[0] <= 16'h0000;
      mem[1] <= 16'h0000;
      ra_q   <= 16'h0000;
      rb_q   <= 16'h0000;
    end else begin
      if (we && wlow) begin
        mem[wchan][7:0] <= wdata;
      end
      if (we && !wlow) begin
        mem[wchan][15:8] <= wdata;
      end
      ra_q <= mem[ra_chan];
      rb_q <= mem[rb_chan];
    end
  end
endmodule // return_info_mem

// ===== test/line_adapter_model.sv
// line adapter model: receive and transmit status registers seen by the monitor
`timescale 1ns/100ps
module line_adapter_model (
  // clock
  input  wire logic       core_clk,
  // status registers toward the monitor
  output logic      [7:0] adapter_status_rx,
  output logic      [7:0] adapter_status_tx
);
  // ==========================================================================
  // status registers
  // bits: dsr, cts, carrier, ring, ready, reserved, overrun, framing/underrun
  logic [7:0] pend [2];

  initial begin
    pend[0] = 8'h00;
    pend[1] = 8'h00;
    adapter_status_rx = 8'h00;
    adapter_status_tx = 8'h00;
  end

  // new status lands just after an edge, as a real line register would
  always @(posedge core_clk) begin
    adapter_status_rx <= pend[0];
    adapter_status_tx <= pend[1];
  end

  // posted by nonblocking assignment so a caller on the edge never races the update
  task automatic set_status(input logic ch, input logic [7:0] x);
    pend[ch] <= x;
  endtask
endmodule // line_adapter_model

// ===== test/line_status_change_monitor_bench.sv
// testbench: line status change monitor against the line adapter model
`timescale 1ns/100ps
module line_status_change_monitor_bench;
  import line_status_pkg::*;
  // ==========================================================================
  // design signals
  logic        core_clk, reset, ccb_begin, ccb_chan, send_req;
  logic        br_req, br_chan, br_on_set, br_done, br_taken;
  logic        term_pulse, start_pulse, action_chan, intr_ack;
  reg_req_s    host_req, cp_req;
  logic [7:0]  host_rdata, cp_rdata, adapter_status_rx, adapter_status_tx;
  intr_s       intr;
  // ==========================================================================
  // bench state
  int          fails = 0, tests_run = 0, cycles = 0, seed = 20;
  logic [7:0]  rq[$];
  logic [18:0] evq[$];
  logic [1:0]  rdp = 2'b00;
  logic        iv_old = 1'b0;
  logic        c;
  logic [7:0]  av[2], s1[2], s2[2], v, msk;
  logic [15:0] retb[2];
  logic [3:0]  ctl;
  logic [2:0]  b;
  logic [3:0]  modes[4] = '{4'h3, 4'h5, 4'h9, 4'hd};
  logic [4:0]  offs[7] = '{OFS_CTL, OFS_RET_HI, OFS_RET_LVL, OFS_COPY, OFS_MASK,
                           OFS_STAT1, OFS_STAT2};

  line_status_change_monitor u_line_status_change_monitor (
    .core_clk, .reset, .host_req, .host_rdata, .cp_req, .cp_rdata,
    .adapter_status_rx, .adapter_status_tx, .ccb_begin, .ccb_chan, .send_req,
    .br_req, .br_chan, .br_on_set, .br_done, .br_taken, .term_pulse,
    .start_pulse, .action_chan, .intr, .intr_ack);

  line_adapter_model u_line_adapter_model (
    .core_clk, .adapter_status_rx, .adapter_status_tx);

  always #20 core_clk = ~core_clk;

  // ==========================================================================
  // compare and report
  task automatic report(input logic [18:0] got, input logic [18:0] e);
    tests_run++;
    if (got !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  task automatic cmp_rd(input logic [7:0] got);
    report({11'h0, got}, {11'h0, rq.pop_front()});
  endtask

  // an action with no note queued is itself a mismatch
  task automatic cmp_ev(input logic [18:0] got);
    if (evq.size() == 0) report(got, ~got);
    else report(got, evq.pop_front());
  endtask

  task automatic end_of_test;
    if (evq.size() != 0) fails++;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================================
  // watchers: read data one cycle after the strobe, pulses and interrupt
  always @(posedge core_clk) begin
    rdp <= {cp_req.rd, host_req.rd};
    intr_ack <= intr.valid & ~intr_ack;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      end_of_test();
    end
  end

  always @(negedge core_clk) begin
    if (rdp[1]) cmp_rd(cp_rdata);
    if (rdp[0]) cmp_rd(host_rdata);
    if (term_pulse | start_pulse) cmp_ev({term_pulse, start_pulse, action_chan, 16'h0});
    if (intr.valid & ~iv_old) cmp_ev({3'b110, intr.chan_num, intr.level});
    if (br_done) cmp_ev({2'b00, br_taken, 16'h0});
    iv_old = intr.valid;
  end

  // ==========================================================================
  // drivers
  task automatic bus(input logic cp, input logic r, input logic [5:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    if (cp) cp_req <= {~r, r, a, d};
    else host_req <= {~r, r, a, d};
    @(posedge core_clk);
    host_req <= '0;
    cp_req <= '0;
  endtask

  task automatic rd(input logic cp, input logic [5:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(cp, 1'b1, a, 8'h00);
  endtask

  task automatic strobe(input logic [2:0] w, input logic ch, input logic os);
    @(posedge core_clk);
    {br_req, ccb_begin, send_req} <= w;
    ccb_chan <= ch;
    br_chan <= ch;
    br_on_set <= os;
    @(posedge core_clk);
    {br_req, ccb_begin, send_req} <= 3'b000;
  endtask

  task automatic adapt(input logic ch, input logic [7:0] x);
    av[ch] = x;
    u_line_adapter_model.set_status(ch, x);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    {host_req, cp_req} = '0;
    {ccb_begin, ccb_chan, send_req, br_req, br_chan, br_on_set} = '0;
    s1 = '{8'h00, 8'h00};
    s2 = '{8'h00, 8'h00};
    idle(2);
    reset <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      c = i[0];
      foreach (offs[k]) rd(1'b0, {c, offs[k]}, 8'h00);
      retb[c] = 16'($random(seed));
      bus(1'b0, 1'b0, {c, OFS_RET_HI}, retb[c][15:8]);
      bus(1'b0, 1'b0, {c, OFS_RET_LVL}, retb[c][7:0]);
      bus(1'b1, 1'b0, {c, OFS_RET_HI}, ~retb[c][15:8]);
      bus(1'b1, 1'b0, {c, OFS_COPY}, 8'hff);
      bus(c, 1'b0, {c, OFS_CTL}, 8'hf0);
      rd(1'b0, {c, OFS_RET_HI}, retb[c][15:8]);
      rd(1'b0, {c, OFS_RET_LVL}, retb[c][7:0]);
      rd(1'b1, {c, OFS_RET_LVL}, 8'h00);
      rd(1'b1, {c, OFS_COPY}, 8'h00);
      rd(1'b0, {c, OFS_CTL}, 8'h00);
      rd(1'b0, {c, 5'h05}, 8'h00);
    end
    $display("register test done");
    for (int i = 0; i < 2; i++) begin
      c = i[0];
      bus(1'b0, 1'b0, {c, OFS_MASK}, 8'hff);
      v = 8'($random(seed)) | 8'h01;
      adapt(c, v);
      idle(8);
      rd(1'b0, {c, OFS_COPY}, 8'h00);
      bus(1'b1, 1'b0, {c, OFS_CTL}, 8'h01);
      idle(8);
      rd(1'b1, {c, OFS_COPY}, v);
      for (int m = 0; m < 4; m++) begin
        ctl = modes[m];
        b = 3'($random(seed));
        msk = (8'($random(seed)) | (8'h01 << b)) & ~(8'h01 << (b ^ 3'h4));
        bus(m[0], 1'b0, {c, OFS_MASK}, msk);
        bus(~m[0], 1'b0, {c, OFS_CTL}, {4'h0, ctl});
        rd(1'b0, {c, OFS_MASK}, msk);
        // change an unmasked position first: copy must not follow
        adapt(c, v ^ (8'h01 << (b ^ 3'h4)));
        idle(8);
        rd(1'b0, {c, OFS_COPY}, v);
        v = av[c] ^ (8'h01 << b);
        if (ctl[CTL_INTR]) begin
          evq.push_back({2'b10, c, 16'h0});
          evq.push_back({3'b110, retb[c]});
          s1[c][STAT1_CHANGE_INTR] = 1'b1;
        end else if (ctl[CTL_START]) evq.push_back({2'b01, c, 16'h0});
        if (ctl[CTL_FLAG]) s2[c][STAT2_CHANGE] = 1'b1;
        adapt(c, v);
        idle(12);
        rd(1'b0, {c, OFS_COPY}, v);
        rd(1'b0, {c, OFS_STAT1}, s1[c]);
        rd(1'b1, {c, OFS_STAT2}, s2[c]);
      end
      bus(1'b0, 1'b0, {c, OFS_CTL}, 8'h00);
    end
    $display("scan test done");
    adapt(1'b1, 8'h10);
    idle(2);
    strobe(3'b001, 1'b1, 1'b0);
    rd(1'b0, {1'b1, OFS_STAT1}, s1[1]);
    adapt(1'b1, 8'h80);
    idle(2);
    strobe(3'b001, 1'b1, 1'b0);
    s1[1][STAT1_SERVICE_ERR] = 1'b1;
    rd(1'b0, {1'b1, OFS_STAT1}, s1[1]);
    strobe(3'b010, 1'b1, 1'b0);
    rd(1'b1, {1'b1, OFS_STAT1}, 8'h00);
    rd(1'b0, {1'b1, OFS_STAT2}, 8'h00);
    bus(1'b1, 1'b0, {1'b1, OFS_STAT1}, 8'hff);
    bus(1'b0, 1'b0, {1'b1, OFS_STAT2}, 8'hff);
    rd(1'b0, {1'b1, OFS_STAT1}, STAT1_PROG_MASK);
    rd(1'b1, {1'b1, OFS_STAT2}, 8'h00);
    $display("send test done");
    adapt(1'b0, 8'h10);
    idle(2);
    for (int i = 0; i < 4; i++) begin
      evq.push_back({2'b00, av[i % 2][LS_READY] == i[1], 16'h0});
      strobe(3'b100, i[0], i[1]);
    end
    idle(4);
    $display("branch test done");
    end_of_test();
  end
endmodule // line_status_change_monitor_bench
